/* File: spc_pkg.sv */
package spc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPC_P1_CTRL_B_OFS = 8'h1d;
  localparam logic [7:0] SPC_P1_STAT_A_OFS = 8'h1e;
  localparam logic [7:0] SPC_P1_STAT_B_OFS = 8'h1f;
  localparam logic [7:0] SPC_P2_CTRL_B_OFS = 8'h2d;
  localparam logic [7:0] SPC_P2_STAT_A_OFS = 8'h2e;
  localparam logic [7:0] SPC_P2_STAT_B_OFS = 8'h2f;
  localparam logic [7:0] SPC_P3_CTRL_HOLE_OFS = 8'h3d;
  localparam logic [7:0] SPC_P3_STAT_HOLE_OFS = 8'h3e;
  localparam logic [7:0] SPC_P3_STAT_B_OFS = 8'h3f;
  localparam logic [7:0] SPC_DSCP_MAP0_OFS = 8'h60;
  localparam logic [7:0] SPC_DSCP_MAP1_OFS = 8'h61;
  localparam logic [7:0] SPC_DSCP_MAP2_OFS = 8'h62;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int SPC_CB_RESTART_AN = 5;
  localparam int SPC_CB_FEF_DIS = 4;
  localparam int SPC_CB_PWR_DOWN = 3;
  localparam int SPC_CB_MDIX_DIS = 2;
  localparam int SPC_CB_FORCE_MDI = 1;
  localparam int SPC_CB_LOOPBACK = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SPC_CTRL_RST = 8'h00;
  localparam logic [7:0] SPC_DSCP_RST = 8'h00;
  localparam logic [2:0] SPC_STAT_B_RSVD = 3'h0;

  // ----------------------------------------------------------------
  // Management view of a PHY port (standard register selector)
  // ----------------------------------------------------------------
  localparam logic [1:0] SPC_MIIM_CTRL_A = 2'h0;
  localparam logic [1:0] SPC_MIIM_CTRL_B = 2'h1;
  localparam logic [1:0] SPC_MIIM_STAT_A = 2'h2;

  // Live status from one PHY port
  typedef struct packed {
    logic mdix;
    logic an_done;
    logic link_good;
    logic partner_pause;
    logic [3:0] partner_abil;
  } spc_phy_stat_s;

  // Live status from one MAC port
  typedef struct packed {
    logic rx_fc_active;
    logic tx_fc_active;
    logic speed_100;
    logic full_duplex;
    logic far_end_fault;
  } spc_mac_stat_s;

  // Control bits driven to one PHY
  typedef struct packed {
    logic restart_an;
    logic fef_disable;
    logic power_down;
    logic mdix_disable;
    logic force_mdi;
    logic tx_on_receive_pair;
  } spc_phy_ctl_s;

endpackage : spc_pkg

/* File: spc_port_regs.sv */
`timescale 1ns/100ps

// How it works
// - Bit 4 disables far-end-fault detect and pattern; port 1 only, resets 0.
// - Bit 3 powers the port PHY down; clear is normal; resets 0.
// - Bit 2 disables auto crossover; port 2 reset value from strap.
// - Bit 1 forces MDI (one) or MDI-X (zero) when auto is off.
// - Port 1 loopback returns port 2 receive data on port 2 transmit.
// - Port 2 loopback returns port 1 receive data on port 1 transmit.
// - Status bits 7,6,5: crossover state, negotiation done, link good.
// - Status bit 4: partner advertised pause capability.
// - Status bits 3..0: partner 100F, 100H, 10F, 10H abilities.
// - Second status bit 4: receive flow control active.
// - Second status bit 3: transmit flow control active.
// - Second status bit 2: speed, one is 100 Mb/s.
// - Second status bit 1: duplex, one is full.
// - Second status bit 0: far-end fault, port 1 only.
// - Second status exists for all three ports; bits 7..5 read zero.
// - Port 3 control and first status addresses are reserved.
// - Six TOS bits decode to one of 64 map positions.
// - Selected map bit one gives high priority, zero low.
// - Map bits 63..40 stored MSB first at 0x60..0x62, each resets to zero; bits 39..0 come from dscp_map_low.
// - Control and first status also reachable via PHY management port.
// - Bit 5 restarts auto-negotiation; zero is normal operation.
module spc_port_regs
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic miim_port,
  input wire logic [1:0] miim_sel,
  input wire logic miim_wr,
  input wire logic [7:0] miim_wdata,
  input wire logic [7:0] miim_ctrl_a_p1,
  input wire logic [7:0] miim_ctrl_a_p2,
  output logic [7:0] miim_rdata,
  input wire logic port2_crossover_strap_pin,
  input wire logic port2_force_mdi_strap_pin,
  input wire spc_phy_stat_s phy_stat_p1,
  input wire spc_phy_stat_s phy_stat_p2,
  input wire spc_mac_stat_s mac_stat_p1,
  input wire spc_mac_stat_s mac_stat_p2,
  input wire spc_mac_stat_s mac_stat_p3,
  output spc_phy_ctl_s phy_ctl_p1,
  output spc_phy_ctl_s phy_ctl_p2,
  input wire logic [4:0] rx_sym_p1,
  input wire logic [4:0] rx_sym_p2,
  input wire logic [4:0] mac_tx_sym_p1,
  input wire logic [4:0] mac_tx_sym_p2,
  output logic [4:0] tx_sym_p1,
  output logic [4:0] tx_sym_p2,
  input wire logic [39:0] dscp_map_low,
  input wire logic tos_valid,
  input wire logic [5:0] tos_dscp,
  output logic prio_valid,
  output logic prio_high
);

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  logic [1:0] strap_meta_reg;
  logic [1:0] strap_sync_reg;

  // Straps are slow pins; sampled through two flops even in reset
  always_ff @(posedge clk) begin
    if (ce) begin
      strap_meta_reg <= {port2_crossover_strap_pin,
                         port2_force_mdi_strap_pin};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_p1_reg;
  logic [7:0] ctrl_p2_reg;
  logic [23:0] dscp_map_reg;
  logic wr_p1;
  logic wr_p2;
  logic [7:0] wr_p1_data;
  logic [7:0] wr_p2_data;

  // Register port wins over the management port on a clash
  always_comb begin
    wr_p1 = reg_wr && reg_addr == SPC_P1_CTRL_B_OFS;
    wr_p2 = reg_wr && reg_addr == SPC_P2_CTRL_B_OFS;
    wr_p1_data = reg_wdata;
    wr_p2_data = reg_wdata;
    if (!reg_wr && miim_wr && miim_sel == SPC_MIIM_CTRL_B) begin
      wr_p1 = !miim_port;
      wr_p2 = miim_port;
      wr_p1_data = miim_wdata;
      wr_p2_data = miim_wdata;
    end
  end

  // Reset obeys the enable too, so a frozen block keeps its state
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!rst_n) begin
        ctrl_p1_reg <= SPC_CTRL_RST;
      end else if (wr_p1) begin
        ctrl_p1_reg <= wr_p1_data;
      end
    end
  end

  // Port 2 strap bits reload on every reset cycle with ce high, from synced pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      if (ce) begin
        ctrl_p2_reg <= SPC_CTRL_RST;
        ctrl_p2_reg[SPC_CB_MDIX_DIS] <= strap_sync_reg[1];
        ctrl_p2_reg[SPC_CB_FORCE_MDI] <= strap_sync_reg[0];
      end
    end else if (ce && wr_p2) begin
      ctrl_p2_reg <= wr_p2_data;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (!rst_n) begin
        dscp_map_reg <= {3{SPC_DSCP_RST}};
      end else if (reg_wr) begin
        case (reg_addr)
          SPC_DSCP_MAP0_OFS: dscp_map_reg[23:16] <= reg_wdata;
          SPC_DSCP_MAP1_OFS: dscp_map_reg[15:8] <= reg_wdata;
          SPC_DSCP_MAP2_OFS: dscp_map_reg[7:0] <= reg_wdata;
          default: dscp_map_reg <= dscp_map_reg;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status assembly
  // ----------------------------------------------------------------
  function automatic logic [7:0] stat_a(input spc_phy_stat_s s);
    stat_a = {s.mdix, s.an_done, s.link_good,
              s.partner_pause, s.partner_abil};
  endfunction : stat_a

  function automatic logic [7:0] stat_b(input spc_mac_stat_s s,
                                        input logic fef_ok);
    stat_b = {SPC_STAT_B_RSVD, s.rx_fc_active,
              s.tx_fc_active, s.speed_100,
              s.full_duplex, s.far_end_fault & fef_ok};
  endfunction : stat_b

  // Fault only meaningful on the fibre port, and not while disabled
  logic fef_p1_ok;
  assign fef_p1_ok = !ctrl_p1_reg[SPC_CB_FEF_DIS];

  // ----------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------
  // Combinational and side-effect free: reading never alters state
  always_comb begin
    case (reg_addr)
      SPC_P1_CTRL_B_OFS: reg_rdata = ctrl_p1_reg;
      SPC_P1_STAT_A_OFS: reg_rdata = stat_a(phy_stat_p1);
      SPC_P1_STAT_B_OFS: reg_rdata = stat_b(mac_stat_p1, fef_p1_ok);
      SPC_P2_CTRL_B_OFS: reg_rdata = ctrl_p2_reg;
      SPC_P2_STAT_A_OFS: reg_rdata = stat_a(phy_stat_p2);
      SPC_P2_STAT_B_OFS: reg_rdata = stat_b(mac_stat_p2, 1'b0);
      SPC_P3_STAT_B_OFS: reg_rdata = stat_b(mac_stat_p3, 1'b0);
      SPC_DSCP_MAP0_OFS: reg_rdata = dscp_map_reg[23:16];
      SPC_DSCP_MAP1_OFS: reg_rdata = dscp_map_reg[15:8];
      SPC_DSCP_MAP2_OFS: reg_rdata = dscp_map_reg[7:0];
      default: reg_rdata = 8'h00;
    endcase
  end

  always_comb begin
    case (miim_sel)
      SPC_MIIM_CTRL_A: miim_rdata = miim_port ? miim_ctrl_a_p2
                                              : miim_ctrl_a_p1;
      SPC_MIIM_CTRL_B: miim_rdata = miim_port ? ctrl_p2_reg : ctrl_p1_reg;
      SPC_MIIM_STAT_A: miim_rdata = miim_port ? stat_a(phy_stat_p2)
                                              : stat_a(phy_stat_p1);
      default: miim_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // PHY controls
  // ----------------------------------------------------------------
  function automatic spc_phy_ctl_s phy_ctl(input logic [7:0] c,
                                          input logic mdix_now,
                                          input logic fibre);
    phy_ctl.restart_an = c[SPC_CB_RESTART_AN];
    phy_ctl.fef_disable = fibre & c[SPC_CB_FEF_DIS];
    phy_ctl.power_down = c[SPC_CB_PWR_DOWN];
    phy_ctl.mdix_disable = c[SPC_CB_MDIX_DIS];
    phy_ctl.force_mdi = c[SPC_CB_FORCE_MDI];
    // MDI transmits on the receive-named pair
    phy_ctl.tx_on_receive_pair = c[SPC_CB_MDIX_DIS] ? c[SPC_CB_FORCE_MDI]
                                                    : !mdix_now;
  endfunction : phy_ctl

  always_ff @(posedge clk) begin
    if (ce) begin
      if (!rst_n) begin
        phy_ctl_p1 <= '0;
        phy_ctl_p2 <= '0;
      end else begin
        phy_ctl_p1 <= phy_ctl(ctrl_p1_reg, phy_stat_p1.mdix, 1'b1);
        phy_ctl_p2 <= phy_ctl(ctrl_p2_reg, phy_stat_p2.mdix, 1'b0);
      end
    end
  end

  // ----------------------------------------------------------------
  // Loopback steering
  // ----------------------------------------------------------------
  // Loop is named after the PHY doing the turnaround, not the pins
  always_ff @(posedge clk) begin
    if (ce) begin
      if (!rst_n) begin
        tx_sym_p1 <= 5'h00;
        tx_sym_p2 <= 5'h00;
      end else begin
        tx_sym_p2 <= ctrl_p1_reg[SPC_CB_LOOPBACK] ? rx_sym_p2
                                                  : mac_tx_sym_p2;
        tx_sym_p1 <= ctrl_p2_reg[SPC_CB_LOOPBACK] ? rx_sym_p1
                                                  : mac_tx_sym_p1;
      end
    end
  end

  // ----------------------------------------------------------------
  // DSCP priority lookup
  // ----------------------------------------------------------------
  logic [63:0] dscp_map;
  logic [63:0] dscp_onehot;
  assign dscp_map = {dscp_map_reg, dscp_map_low};
  assign dscp_onehot = 64'h1 << tos_dscp;

  always_ff @(posedge clk) begin
    if (ce) begin
      if (!rst_n) begin
        prio_valid <= 1'b0;
        prio_high <= 1'b0;
      end else begin
        prio_valid <= tos_valid;
        prio_high <= |(dscp_onehot & dscp_map);
      end
    end
  end

endmodule : spc_port_regs

/* File: spc_port_regs_assertions.sv */
`timescale 1ns/100ps
// ------------------------------
// Port register checks
// ------------------------------
module spc_port_regs_assertions
  import spc_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic ce,
  input logic [7:0] reg_addr,
  input logic reg_wr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input spc_phy_stat_s phy_stat_p1,
  input spc_mac_stat_s mac_stat_p3,
  input spc_phy_ctl_s phy_ctl_p1,
  input logic [4:0] rx_sym_p1,
  input logic [4:0] rx_sym_p2,
  input logic [4:0] tx_sym_p1,
  input logic [4:0] tx_sym_p2,
  input logic tos_valid,
  input logic prio_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_prio_answer: assert property (
    ce && tos_valid |=> prio_valid) else $error("no prio answer");
  chk_hole_zero: assert property (
    reg_addr == SPC_P3_CTRL_HOLE_OFS || reg_addr == SPC_P3_STAT_HOLE_OFS
    |-> reg_rdata == 8'h00) else $error("hole not zero");
  chk_p3_status_b: assert property (
    reg_addr == SPC_P3_STAT_B_OFS
    |-> reg_rdata == {3'h0, mac_stat_p3[4:1], 1'b0}) else $error("p3 stat");
  chk_status_live: assert property (
    reg_addr == SPC_P1_STAT_A_OFS |-> reg_rdata == phy_stat_p1)
    else $error("status not live");
  chk_power_down: assert property (
    ce && reg_wr && reg_addr == SPC_P1_CTRL_B_OFS && reg_wdata[3]
    |-> ##2 phy_ctl_p1.power_down) else $error("no power down");
  chk_loop_p1: assert property (
    ce && reg_addr == SPC_P1_CTRL_B_OFS && reg_rdata[0]
    |=> tx_sym_p2 == $past(rx_sym_p2)) else $error("p1 loop");
  chk_loop_p2: assert property (
    ce && reg_addr == SPC_P2_CTRL_B_OFS && reg_rdata[0]
    |=> tx_sym_p1 == $past(rx_sym_p1)) else $error("p2 loop");
  chk_map_write: assert property (
    ce && reg_wr && reg_addr == SPC_DSCP_MAP0_OFS ##1
    reg_addr == SPC_DSCP_MAP0_OFS |-> reg_rdata == $past(reg_wdata))
    else $error("map write lost");
  cover property (ce && tos_valid);
  cover property (reg_wr && reg_addr == SPC_DSCP_MAP0_OFS);
  cover property (phy_ctl_p1.power_down);
endmodule : spc_port_regs_assertions

bind spc_port_regs spc_port_regs_assertions i_chk (.clk, .rst_n, .ce,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .phy_stat_p1, .mac_stat_p3,
  .phy_ctl_p1, .rx_sym_p1, .rx_sym_p2, .tx_sym_p1, .tx_sym_p2, .tos_valid,
  .prio_valid);

/* File: spc_link_partner.sv */
`timescale 1ns/100ps
// ------------------------------
// Cable-side link partner
// ------------------------------
module spc_link_partner
  import spc_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic [3:0] abil,
  input logic pause,
  input spc_phy_ctl_s phy_ctl_p1,
  input spc_phy_ctl_s phy_ctl_p2,
  output spc_phy_stat_s phy_stat_p1,
  output spc_phy_stat_s phy_stat_p2,
  output logic [4:0] rx_sym_p1,
  output logic [4:0] rx_sym_p2
);
  logic [4:0] cnt_reg;
  // Symbols move every cycle so a stale copy never matches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end
  assign rx_sym_p1 = cnt_reg;
  assign rx_sym_p2 = ~cnt_reg;
  // Link drops while the local PHY sleeps
  assign phy_stat_p1 = {2'h3, !phy_ctl_p1.power_down, pause, abil};
  assign phy_stat_p2 = {2'h1, !phy_ctl_p2.power_down, pause, abil};
endmodule : spc_link_partner

/* File: spc_port_regs_tb_top.sv */
`timescale 1ns/100ps
module spc_port_regs_tb_top
  import spc_pkg::*;
;
  // ------------------------------
  // Bench signals
  // ------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ca = 8'h5a;
  logic reg_wr = 1'b0, tos_valid = 1'b0, pause = 1'b1, ce = 1'b1;
  logic [7:0] reg_rdata, miim_rdata, miim_wdata = 8'h00;
  logic miim_port = 1'b0, miim_wr = 1'b0, prio_valid, prio_high;
  logic [1:0] miim_sel = 2'h0;
  logic [5:0] tos_dscp = 6'h00;
  logic [3:0] abil = 4'ha;
  logic [4:0] rx_sym_p1, rx_sym_p2, tx_sym_p1, tx_sym_p2;
  logic [7:0] hole [3] = '{8'h3d, 8'h3e, 8'h70};
  spc_phy_stat_s phy_stat_p1, phy_stat_p2;
  spc_phy_ctl_s phy_ctl_p1, phy_ctl_p2;
  spc_mac_stat_s ms1 = 5'h1f, ms2 = 5'h1f, ms3 = 5'h1f;
  int n_fail = 0, n_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  spc_link_partner i_lp (.clk, .rst_n, .abil, .pause, .phy_ctl_p1,
    .phy_ctl_p2, .phy_stat_p1, .phy_stat_p2, .rx_sym_p1, .rx_sym_p2);
  spc_port_regs i_dut (.clk, .rst_n, .ce, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .miim_port, .miim_sel, .miim_wr, .miim_wdata,
    .miim_ctrl_a_p1(ca), .miim_ctrl_a_p2(8'ha5), .miim_rdata,
    .port2_crossover_strap_pin(1'b1), .port2_force_mdi_strap_pin(1'b0),
    .phy_stat_p1, .phy_stat_p2, .mac_stat_p1(ms1), .mac_stat_p2(ms2),
    .mac_stat_p3(ms3), .phy_ctl_p1, .phy_ctl_p2, .rx_sym_p1, .rx_sym_p2,
    .mac_tx_sym_p1(rx_sym_p2), .mac_tx_sym_p2(rx_sym_p1), .tx_sym_p1,
    .tx_sym_p2, .dscp_map_low(40'h0), .tos_valid, .tos_dscp, .prio_valid,
    .prio_high);
  // ------------------------------
  // Access tasks
  // ------------------------------
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk);
    reg_addr = a;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic pri(input logic [5:0] c, input logic e);
    @(negedge clk);
    tos_valid = 1'b1;
    tos_dscp = c;
    @(negedge clk);
    tos_valid = 1'b0;
    chk({7'h0, prio_valid}, 8'h01);
    chk({7'h0, prio_high}, {7'h0, e});
  endtask : pri
  task automatic finish_test;
    $display("n_checks %0d n_fail %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Bound on a hang; the sequence needs under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    rd(SPC_P1_CTRL_B_OFS, SPC_CTRL_RST);
    rd(SPC_P2_CTRL_B_OFS, 8'h04);
    for (int i = 0; i < 3; i++) rd(SPC_DSCP_MAP0_OFS + 8'(i), 8'h00);
    rd(SPC_P1_STAT_A_OFS, 8'hfa);
    rd(SPC_P2_STAT_A_OFS, 8'h7a);
    wr(SPC_P1_CTRL_B_OFS, 8'h08);
    rd(SPC_P1_STAT_A_OFS, 8'hda);
    for (int k = 0; k < 2; k++) begin
      wr(SPC_P1_CTRL_B_OFS, 8'h24 | 8'(k << 1));
      @(negedge clk);
      chk({7'h0, phy_ctl_p1.restart_an}, 8'h01);
      chk({7'h0, phy_ctl_p1.mdix_disable}, 8'h01);
      chk({7'h0, phy_ctl_p1.tx_on_receive_pair}, 8'(k));
    end
    rd(SPC_P1_STAT_B_OFS, 8'h1f);
    rd(SPC_P2_STAT_B_OFS, 8'h1e);
    for (int b = 0; b < 4; b++) begin
      ms3 = 5'(2 << b);
      rd(SPC_P3_STAT_B_OFS, 8'(2 << b));
    end
    wr(SPC_P1_CTRL_B_OFS, 8'h10);
    rd(SPC_P1_STAT_B_OFS, 8'h1e);
    wr(SPC_P1_STAT_B_OFS, 8'hff);
    rd(SPC_P1_STAT_B_OFS, 8'h1e);
    for (int h = 0; h < 3; h++) begin
      wr(hole[h], 8'hff);
      rd(hole[h], 8'h00);
    end
    wr(SPC_P1_CTRL_B_OFS, 8'h01);
    rd(SPC_P1_CTRL_B_OFS, 8'h01);
    chk({3'h0, tx_sym_p2}, {3'h0, rx_sym_p2 + 5'h01});
    wr(SPC_P2_CTRL_B_OFS, 8'h01);
    rd(SPC_P2_CTRL_B_OFS, 8'h01);
    chk({3'h0, tx_sym_p1}, {3'h0, rx_sym_p1 - 5'h01});
    wr(SPC_DSCP_MAP0_OFS, 8'h80);
    wr(SPC_DSCP_MAP1_OFS, 8'h01);
    wr(SPC_DSCP_MAP2_OFS, 8'h80);
    pri(6'd63, 1'b1);
    pri(6'd62, 1'b0);
    pri(6'd48, 1'b1);
    pri(6'd47, 1'b1);
    pri(6'd40, 1'b0);
    @(negedge clk);
    miim_port = 1'b1;
    miim_sel = 2'h1;
    miim_wdata = 8'h08;
    miim_wr = 1'b1;
    @(negedge clk);
    miim_wr = 1'b0;
    rd(SPC_P2_CTRL_B_OFS, 8'h08);
    miim_port = 1'b0;
    miim_sel = 2'h2;
    #1 chk(miim_rdata, 8'hfa);
    miim_sel = 2'h0;
    #1 chk(miim_rdata, ca);
    @(negedge clk);
    ce = 1'b0;
    wr(SPC_DSCP_MAP2_OFS, 8'h55);
    rd(SPC_DSCP_MAP2_OFS, 8'h80);
    ce = 1'b1;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rd(SPC_P1_CTRL_B_OFS, SPC_CTRL_RST);
    rd(SPC_P2_CTRL_B_OFS, 8'h04);
    rd(SPC_DSCP_MAP0_OFS, SPC_DSCP_RST);
    finish_test();
  end
endmodule : spc_port_regs_tb_top
